/* File: ssf_top.sv */
// serial frame peripheral: slave link engine and move-counter master engine

// Overview of operation
// - On transmit underflow the slave drives every data bit as one.
// - Slave parity is computed from the bits actually sent, underflow included.
// - Received frame is always stored, even if bit order changes meanwhile.
// - Transmit underflow never blocks storing the received frame.
// - Move counter current count never underflows with next data already queued.
// - Event code 101 on either selector gives end-of-frame interrupt for refills.
// - Slave select deassertion clears the slave in-frame flag, so the next selection restarts the bit count at zero.
// - Selector b set to 101 with its enable raises interrupt on deselection in slave mode.
// - Reset request value 01 clears bit counter and protocol state machine.
module ssf_top
  import ssf_pkg::*;
#(
  parameter int HALF_CYC = MST_HALF_CYC
)
(
  // system clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // configuration
  input wire logic master_mode,
  input wire ssf_cfg_t frame_control_word,
  input wire logic move_counter_enable,
  input wire logic [MC_W-1:0] move_count_load,
  input wire logic [2:0] phase_event_select_a,
  input wire logic phase_event_a_irq_enable,
  input wire logic [2:0] phase_event_select_b,
  input wire logic phase_event_b_irq_enable,
  input wire logic [1:0] reset_request_field,
  input wire logic reset_request_we,
  // transmit word
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // receive word
  output logic [DATA_W-1:0] rx_data,
  output logic rx_valid,
  output logic rx_underflow,
  // status
  output logic phase_irq,
  output logic [MC_W-1:0] move_counter_current,
  // slave link, clocked by the external master
  input wire logic link_sclk,
  input wire logic slave_select_input_n,
  input wire logic slave_mosi,
  output logic slave_miso_o,
  output logic slave_miso_oe,
  // master link
  output logic mst_sclk,
  output logic mst_mosi,
  output logic mst_sel_n
);

  ssf_lnk_t lq, ld;
  ssf_sys_t sq, sd;
  logic lnk_rst_b;
  logic lnk_sel_q;

  function automatic logic [DATA_W-1:0] rev(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      r[i] = v[DATA_W-1-i];
    end
    return r;
  endfunction

  // deselect or an engine reset request ends the frame in progress
  assign lnk_rst_b = rst_b & ~slave_select_input_n & ~sq.soft_rst;

  // only this in-frame flag is cleared there; clearing the toggles too would
  // fake a handshake edge on the system side
  always_ff @(posedge link_sclk or negedge lnk_rst_b)
  begin
    if (!lnk_rst_b)
    begin
      lnk_sel_q <= 1'b0;
    end
    else
    begin
      lnk_sel_q <= 1'b1;
    end
  end

  // link domain: launch and capture on the rising shift clock
  always_comb
  begin
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] full;
    logic [CNT_W-1:0] last;
    logic [CNT_W-1:0] cur;
    // first edge of a selection always opens a frame, whatever count was left
    cur = lnk_sel_q ? lq.cnt : '0;
    w = lq.sh;
    full = {lq.rx[DATA_W-2:0], slave_mosi};
    last = lq.cfg.par_en ? CNT_W'(DATA_W) : CNT_W'(DATA_W - 1);
    ld = lq;
    ld.txf_s1 = sq.tx_full;
    ld.txf_s2 = lq.txf_s1;
    ld.cfg_s1 = frame_control_word;
    ld.cfg_s2 = lq.cfg_s1;
    if (cur == '0)
    begin
      // bit order and parity are latched per frame, so a rewrite only hits the next one
      ld.cfg = lq.cfg_s2;
      // an empty word is not waited for: the frame shifts on as all ones
      ld.uf = ~lq.txf_s2 || sq.m_ss_n == 1'b0 || master_mode;
      w = ld.uf ? '1 : sq.tx_word;
      ld.par = ^w ^ lq.cfg_s2.par_odd;
      w = lq.cfg_s2.msb_first ? w : rev(w);
      if (!ld.uf)
      begin
        ld.take_tgl = ~lq.take_tgl;
      end
      last = lq.cfg_s2.par_en ? CNT_W'(DATA_W) : CNT_W'(DATA_W - 1);
    end
    if (cur < CNT_W'(DATA_W))
    begin
      ld.miso = w[DATA_W-1];
      ld.sh = {w[DATA_W-2:0], 1'b0};
      ld.rx = full;
    end
    else
    begin
      ld.miso = lq.par;
    end
    if (cur == CNT_W'(DATA_W - 1))
    begin
      // store is unconditional: neither underflow nor a new bit order suppresses it
      ld.rx_hold = ld.cfg.msb_first ? full : rev(full);
      ld.rx_uf = ld.uf;
      ld.rx_tgl = ~lq.rx_tgl;
    end
    ld.cnt = (cur == last) ? '0 : cur + CNT_W'(1);
  end

  always_ff @(posedge link_sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lq <= LNK_RST;
    end
    else
    begin
      lq <= ld;
    end
  end

  // system domain
  always_comb
  begin
    logic tick;
    logic eof_ev;
    logic sof_ev;
    logic dsel_ev;
    logic load;
    logic [DATA_W-1:0] word;
    logic hit_a;
    logic hit_b;
    sd = sq;
    tick = (sq.div == DIV_W'(HALF_CYC - 1));
    eof_ev = 1'b0;
    sof_ev = 1'b0;
    load = 1'b0;
    word = sq.tx_word;
    hit_a = 1'b0;
    hit_b = 1'b0;
    dsel_ev = sq.ss_s[1] & ~sq.ss_s[2] & ~master_mode;
    sd.take_s = {sq.take_s[1:0], lq.take_tgl};
    sd.rx_s = {sq.rx_s[1:0], lq.rx_tgl};
    sd.ss_s = {sq.ss_s[1:0], slave_select_input_n};
    sd.rx_valid = 1'b0;
    if (sq.rx_s[1] ^ sq.rx_s[2])
    begin
      sd.rx_data = lq.rx_hold;
      sd.rx_uf = lq.rx_uf;
      sd.rx_valid = 1'b1;
    end
    if (sq.take_s[1] ^ sq.take_s[2])
    begin
      sd.tx_full = 1'b0;
    end
    sd.div = (tick || sq.st == SSF_IDLE) ? '0 : sq.div + DIV_W'(1);
    unique case (sq.st)
      SSF_IDLE:
      begin
        if (master_mode && sq.tx_full)
        begin
          // count reloads only here, never while a trailing phase is still open
          sd.mc_cur = move_counter_enable ? move_count_load : MC_W'(1);
          sd.m_ss_n = 1'b0;
          sd.st = SSF_LEAD;
        end
      end
      SSF_LEAD:
      begin
        if (tick)
        begin
          load = 1'b1;
          sd.st = SSF_SHIFT;
        end
      end
      SSF_SHIFT:
      begin
        if (tick)
        begin
          sd.m_sclk = ~sq.m_sclk;
          if (sq.m_sclk)
          begin
            if (sq.bcnt == CNT_W'(DATA_W - 1))
            begin
              eof_ev = 1'b1;
              // saturate: queued data for the next transaction cannot wrap it
              sd.mc_cur = (sq.mc_cur == '0) ? '0 : sq.mc_cur - MC_W'(1);
              if (move_counter_enable && sq.mc_cur > MC_W'(1))
              begin
                load = sq.tx_full;
                sd.st = sq.tx_full ? SSF_SHIFT : SSF_AWAIT;
              end
              else
              begin
                sd.st = SSF_TRAIL;
              end
            end
            else
            begin
              sd.bcnt = sq.bcnt + CNT_W'(1);
              sd.m_mosi = sq.msh[DATA_W-1];
              sd.msh = {sq.msh[DATA_W-2:0], 1'b0};
            end
          end
        end
      end
      SSF_AWAIT:
      begin
        if (sq.tx_full)
        begin
          load = 1'b1;
          sd.st = SSF_SHIFT;
        end
      end
      SSF_TRAIL:
      begin
        if (tick)
        begin
          sd.m_ss_n = 1'b1;
          sd.st = SSF_IDLE;
        end
      end
      default:
      begin
        sd.st = SSF_IDLE;
      end
    endcase
    if (load)
    begin
      word = frame_control_word.msb_first ? sq.tx_word : rev(sq.tx_word);
      sd.m_mosi = word[DATA_W-1];
      sd.msh = {word[DATA_W-2:0], 1'b0};
      sd.bcnt = '0;
      sd.tx_full = 1'b0;
      sof_ev = 1'b1;
    end
    // in slave mode link takes the word by toggle; master takes it directly
    if (tx_valid && !sq.tx_full)
    begin
      sd.tx_word = tx_data;
      sd.tx_full = 1'b1;
    end
    hit_a = (phase_event_select_a == PH_EOF && (eof_ev || dsel_ev))
      || (phase_event_select_a == PH_SOF && sof_ev);
    hit_b = (phase_event_select_b == PH_EOF && (eof_ev || dsel_ev))
      || (phase_event_select_b == PH_SOF && sof_ev);
    sd.irq = (phase_event_a_irq_enable && hit_a) || (phase_event_b_irq_enable && hit_b);
    sd.soft_rst = reset_request_we && reset_request_field == RST_REQ_ENGINE;
    if (sq.soft_rst)
    begin
      sd.st = SSF_IDLE;
      sd.bcnt = '0;
      sd.m_ss_n = 1'b1;
      sd.m_sclk = 1'b0;
      sd.div = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sq <= SYS_RST;
    end
    else
    begin
      sq <= sd;
    end
  end

  assign tx_ready = ~sq.tx_full;
  assign rx_data = sq.rx_data;
  assign rx_valid = sq.rx_valid;
  assign rx_underflow = sq.rx_uf;
  assign phase_irq = sq.irq;
  assign move_counter_current = sq.mc_cur;
  assign slave_miso_o = lq.miso;
  assign slave_miso_oe = lnk_sel_q;
  assign mst_sclk = sq.m_sclk;
  assign mst_mosi = sq.m_mosi;
  assign mst_sel_n = sq.m_ss_n;

endmodule

/* File: ssf_pkg.sv */
// shared constants, states and state records of the serial frame block
package ssf_pkg;
  localparam int DATA_W = 8;
  localparam int CNT_W = $clog2(DATA_W + 2);
  localparam int CLK_PERIOD_NS = 10;
  localparam int MST_HALF_NS = 50;
  localparam int MST_HALF_CYC = (MST_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : MST_HALF_NS / CLK_PERIOD_NS;
  localparam int DIV_W = $clog2(MST_HALF_CYC + 1);
  localparam int MC_W = 8;
  localparam logic [2:0] PH_SOF = 3'h2;
  localparam logic [2:0] PH_EOF = 3'h5;
  localparam logic [1:0] RST_REQ_ENGINE = 2'h1;

  // gray along idle -> lead -> shift -> trail, await branches off shift
  typedef enum logic [2:0] {
    SSF_IDLE = 3'b000,
    SSF_LEAD = 3'b001,
    SSF_SHIFT = 3'b011,
    SSF_TRAIL = 3'b010,
    SSF_AWAIT = 3'b110
  } ssf_mst_t;

  typedef struct packed {
    logic msb_first;
    logic par_en;
    logic par_odd;
  } ssf_cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] sh;
    logic [DATA_W-1:0] rx;
    ssf_cfg_t cfg;
    logic par;
    logic uf;
    logic miso;
    logic [DATA_W-1:0] rx_hold;
    logic rx_uf;
    logic rx_tgl;
    logic take_tgl;
    logic txf_s1;
    logic txf_s2;
    ssf_cfg_t cfg_s1;
    ssf_cfg_t cfg_s2;
  } ssf_lnk_t;

  typedef struct packed {
    logic [DATA_W-1:0] tx_word;
    logic tx_full;
    logic [2:0] take_s;
    logic [2:0] rx_s;
    logic [2:0] ss_s;
    logic [DATA_W-1:0] rx_data;
    logic rx_valid;
    logic rx_uf;
    logic irq;
    logic soft_rst;
    ssf_mst_t st;
    logic [DIV_W-1:0] div;
    logic [CNT_W-1:0] bcnt;
    logic [DATA_W-1:0] msh;
    logic m_sclk;
    logic m_mosi;
    logic m_ss_n;
    logic [MC_W-1:0] mc_cur;
  } ssf_sys_t;

  localparam ssf_lnk_t LNK_RST = '0;
  localparam ssf_sys_t SYS_RST = '{ss_s: 3'h7, m_ss_n: 1'b1, st: SSF_IDLE, default: '0};
endpackage

/* File: ssf_top_sva.sv */
// port-level assertions for the serial frame peripheral
module ssf_top_sva
  import ssf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic master_mode,
  input wire logic [2:0] phase_event_select_a,
  input wire logic phase_event_a_irq_enable,
  input wire logic [2:0] phase_event_select_b,
  input wire logic phase_event_b_irq_enable,
  input wire logic [1:0] reset_request_field,
  input wire logic reset_request_we,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic phase_irq,
  input wire logic [MC_W-1:0] move_counter_current,
  input wire logic slave_select_input_n,
  input wire logic slave_miso_oe,
  input wire logic mst_sel_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  property p_take;
    tx_valid && tx_ready |=> !tx_ready;
  endproperty
  a_take: assert property (p_take) else $error("word not taken");
  property p_rx_pulse;
    rx_valid |=> !rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse long");
  property p_irq_pulse;
    phase_irq |=> !phase_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse long");
  property p_desel_oe;
    $rose(slave_select_input_n) |-> ##[0:2] !slave_miso_oe;
  endproperty
  a_desel_oe: assert property (p_desel_oe) else $error("oe kept");
  property p_desel_irq;
    $rose(slave_select_input_n) && !master_mode && phase_event_b_irq_enable
      && phase_event_select_b == PH_EOF |-> ##[1:6] phase_irq;
  endproperty
  a_desel_irq: assert property (p_desel_irq) else $error("no deselect irq");
  property p_soft_rst;
    reset_request_we && reset_request_field == RST_REQ_ENGINE |-> ##[1:2] mst_sel_n;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("engine not reset");
  property p_mc_floor;
    move_counter_current == 8'h00 |=> move_counter_current != 8'hFF;
  endproperty
  a_mc_floor: assert property (p_mc_floor) else $error("count wrapped");
  property p_eof_irq;
    master_mode && phase_event_a_irq_enable && phase_event_select_a == PH_EOF
      && !mst_sel_n && move_counter_current == $past(move_counter_current) - 8'h01
      |-> $past(phase_irq) or ##[0:2] phase_irq;
  endproperty
  a_eof_irq: assert property (p_eof_irq) else $error("no end irq");
endmodule

bind ssf_top ssf_top_sva i_sva (.*);

/* File: ssf_ext_master.sv */
// external link master driving the slave side
module ssf_ext_master
(
  // link pins
  output logic sclk,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end
  // n edges in one selection; clock stands still outside it
  task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q);
    q = '0;
    ss_n = 1'b0;
    #33;
    for (int i = 0; i < n; i++)
    begin
      mosi = d[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
      q[i] = miso;
    end
    mosi = ~mosi;
    #30 ss_n = 1'b1;
    // idle gap so the frame is stored before any rewrite
    #60;
  endtask
endmodule

/* File: ssf_top_tb_top.sv */
// self-checking bench for the serial frame peripheral
module ssf_top_tb_top
  import ssf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic master_mode = 1'b0;
  logic move_counter_enable = 1'b0;
  logic phase_event_a_irq_enable = 1'b0;
  logic phase_event_b_irq_enable = 1'b0;
  logic reset_request_we = 1'b0;
  logic tx_valid = 1'b0;
  ssf_cfg_t frame_control_word = '0;
  logic [MC_W-1:0] move_count_load = 8'h00;
  logic [2:0] phase_event_select_a = 3'h0;
  logic [2:0] phase_event_select_b = 3'h0;
  logic [1:0] reset_request_field = 2'h0;
  logic [DATA_W-1:0] tx_data = 8'h00;
  logic tx_ready, rx_valid, rx_underflow, phase_irq, slave_miso_o, slave_miso_oe;
  logic mst_sclk, mst_mosi, mst_sel_n;
  logic [DATA_W-1:0] rx_data;
  logic [MC_W-1:0] move_counter_current;
  wire link_sclk, slave_select_input_n, slave_mosi, miso_w;
  logic [31:0] q;
  logic [31:0] mcap = '0;
  logic [8:0] rxq[$];
  int irq_n = 0, fail_count = 0, n_tests = 0, base;

  always #5 mclk = ~mclk;
  ssf_top #(.HALF_CYC(2)) i_dut (.*);
  // released line shows the inverse, not a stale level
  assign miso_w = slave_miso_oe ? slave_miso_o : ~slave_miso_o;
  ssf_ext_master i_mst (.sclk(link_sclk), .ss_n(slave_select_input_n),
    .mosi(slave_mosi), .miso(miso_w));

  always @(posedge mclk)
  begin
    if (phase_irq === 1'b1)
      irq_n <= irq_n + 1;
    if (rx_valid === 1'b1)
      rxq.push_back({rx_underflow, rx_data});
  end
  always @(posedge mst_sclk)
    mcap <= {mcap[30:0], mst_mosi};

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // negative n waits for an empty word store, else for n irqs
  task automatic await(input int n);
    int i;
    i = 0;
    do
    begin
      @(negedge mclk);
      i++;
    end
    while ((n < 0 ? tx_ready !== 1'b1 : irq_n < n) && i < 5000);
    if (i == 5000)
    begin
      fail_count++;
      end_sim();
    end
  endtask
  task automatic send(input logic [7:0] d);
    await(-1);
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data <= d;
    @(posedge mclk);
    tx_valid <= 1'b0;
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    frame_control_word <= '{1'b1, 1'b1, 1'b0};
    send(8'hC1);
    // first frame of a selection runs before the word is synced: underflow
    fork
      i_mst.xfer(26, 32'h00B4_813C, q);
      begin
        #557;
        @(posedge mclk);
        frame_control_word.msb_first <= 1'b0;
      end
    join
    repeat (5) @(negedge mclk);
    chk(q, 32'h01FF_83FF);
    chk(rxq.size(), 3);
    chk(rxq[0], 9'h13C);
    chk(rxq[1], 9'h081);
    chk(rxq[2], 9'h15A);
    $display("slave frame test done");
    @(posedge mclk);
    phase_event_select_b <= PH_EOF;
    phase_event_b_irq_enable <= 1'b1;
    frame_control_word.par_odd <= 1'b1;
    rxq.delete();
    base = irq_n;
    i_mst.xfer(3, 32'h0000_0005, q);
    i_mst.xfer(9, 32'h0000_00A7, q);
    chk(q, 32'h0000_01FF);
    repeat (5) @(negedge mclk);
    chk(rxq.size(), 1);
    chk(rxq[0], 9'h1A7);
    chk(irq_n - base, 2);
    $display("deselect test done");
    @(posedge mclk);
    master_mode <= 1'b1;
    frame_control_word.msb_first <= 1'b1;
    move_counter_enable <= 1'b1;
    move_count_load <= 8'h03;
    phase_event_select_a <= PH_EOF;
    phase_event_a_irq_enable <= 1'b1;
    phase_event_select_b <= PH_SOF;
    phase_event_b_irq_enable <= 1'b1;
    base = irq_n;
    send(8'hC1);
    send(8'h3C);
    send(8'h81);
    // fourth word lands during the third frame of the first transaction
    send(8'h5A);
    // four end-of-frame and four start-of-frame events, two pairs in one cycle: six irqs
    await(base + 6);
    chk(mcap, 32'hC13C_815A);
    chk(move_counter_current, 8'h02);
    @(posedge mclk);
    reset_request_field <= RST_REQ_ENGINE;
    reset_request_we <= 1'b1;
    @(posedge mclk);
    reset_request_we <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(mst_sel_n, 1'b1);
    $display("move counter test done");
    end_sim();
  end
endmodule
